// *** hdl/mcsfr_core.sv ***
// Core special function registers of the processor
`timescale 1ns/1ps
`default_nettype none
`include "mcsfr_params.svh"
module mcsfr_core
  import mcsfr_pkg::*;
(
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clkEn,
  // Byte access port
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWr,
  input wire logic sfrRd,
  input wire logic [7:0] sfrWdata,
  // Bit access port
  input wire logic bitWr,
  input wire logic [2:0] bitIdx,
  input wire logic bitVal,
  // Datapath result and flags
  input wire logic resultWr,
  input wire logic [7:0] resultIn,
  input wire logic helperWr,
  input wire logic [7:0] helperIn,
  input wire logic carryWr,
  input wire logic carryIn,
  input wire logic halfWr,
  input wire logic halfIn,
  input wire logic ovfWr,
  input wire logic ovfIn,
  // Stack and pointer operations
  input wire mcsfr_stk_t stackOp,
  input wire logic ptrWordWr,
  input wire logic [15:0] ptrWordIn,
  // Read data and decode
  output logic [7:0] sfrRdata,
  output logic sfrHit,
  output logic bitAddressable,
  // Register values
  output logic [7:0] resultOut,
  output logic [7:0] helperOut,
  output logic [7:0] statusOut,
  output logic [7:0] stackTopOut,
  output logic [15:0] addressPointer,
  output logic [4:0] bankBase,
  output logic progWriteMode,
  output logic baudDouble
);
  // ----------------------------------------------------------------
  // Storage and decode
  // ----------------------------------------------------------------
  logic [7:0] result_q;
  logic [7:0] helper_q;
  logic [7:0] stack_q;
  logic [7:0] core_q;
  logic psel_q;
  logic [7:0] rdata_q;
  logic hit_q;
  logic bitOk_q;
  logic [15:0] aptr_q;
  logic [4:0] bank_q;
  logic [7:0] status_q;
  wire [15:0] ptr0;
  wire [15:0] ptr1;
  wire [7:0] statusVal;

  // Bit write turns into read-modify-write of the byte
  function automatic logic [7:0] setBit(input logic [7:0] cur, input logic [2:0] idx,
                                        input logic v);
    logic [7:0] r;
    r = cur;
    r[idx] = v;
    return r;
  endfunction

  function automatic logic isBitCol(input logic [7:0] a);
    return (a & `MCSFR_BITCOL_MASK) == `MCSFR_BITCOL_VAL;
  endfunction

  wire bitOk = isBitCol(sfrAddr);
  wire bitGo = bitWr && bitOk;
  wire anyWr = sfrWr || bitGo;
  wire selResult = sfrAddr == `MCSFR_ADDR_RESULT;
  wire selHelper = sfrAddr == `MCSFR_ADDR_HELPER;
  wire selStatus = sfrAddr == `MCSFR_ADDR_STATUS;
  wire selStack = sfrAddr == `MCSFR_ADDR_STACK;
  wire selP0L = sfrAddr == `MCSFR_ADDR_PTRL;
  wire selP0H = sfrAddr == `MCSFR_ADDR_PTRH;
  wire selP1L = sfrAddr == `MCSFR_ADDR_PTR1L;
  wire selP1H = sfrAddr == `MCSFR_ADDR_PTR1H;
  wire selCore = sfrAddr == `MCSFR_ADDR_CORE;
  wire selPsel = sfrAddr == `MCSFR_ADDR_PSEL;
  wire anySel = selResult | selHelper | selStatus | selStack | selP0L | selP0H
                | selP1L | selP1H | selCore | selPsel;

  // Current byte at the addressed location
  wire [7:0] curByte =
    selResult ? result_q :
    selHelper ? helper_q :
    selStatus ? statusVal :
    selStack ? stack_q :
    selP0L ? ptr0[7:0] :
    selP0H ? ptr0[15:8] :
    selP1L ? ptr1[7:0] :
    selP1H ? ptr1[15:8] :
    selCore ? (core_q & `MCSFR_CC_MASK) :
    selPsel ? {7'h00, psel_q} : `MCSFR_RST_ZERO;

  wire [7:0] wrVal = bitGo ? setBit(curByte, bitIdx, bitVal) : sfrWdata;

  // Word writes go to the selected pointer
  wire w0 = ptrWordWr && !psel_q;
  wire w1 = ptrWordWr && psel_q;
  wire [15:0] activePtr = psel_q ? ptr1 : ptr0;

  // Stack pointer next value
  wire [7:0] stackD =
    (stackOp == MCSFR_STK_PUSH) ? stack_q + 8'h01 :
    (stackOp == MCSFR_STK_POP) ? stack_q - 8'h01 :
    (anyWr && selStack) ? wrVal : stack_q;

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  mcsfr_pointer_pair uPtr0 (
    .sys_clk(sys_clk), .srst(srst), .clkEn(clkEn),
    .wrLow(anyWr && selP0L), .wrHigh(anyWr && selP0H), .wrByte(wrVal),
    .wrWord(w0), .wordIn(ptrWordIn), .value(ptr0)
  );

  mcsfr_pointer_pair uPtr1 (
    .sys_clk(sys_clk), .srst(srst), .clkEn(clkEn),
    .wrLow(anyWr && selP1L), .wrHigh(anyWr && selP1H), .wrByte(wrVal),
    .wrWord(w1), .wordIn(ptrWordIn), .value(ptr1)
  );

  // Parity tracks the current register value, so the status output flop lags a result write by one cycle
  wire [7:0] resultD = resultWr ? resultIn : (anyWr && selResult) ? wrVal : result_q;

  mcsfr_status_word uStatus (
    .sys_clk(sys_clk), .srst(srst), .clkEn(clkEn),
    .swWr(anyWr && selStatus), .swData(wrVal),
    .carryWr(carryWr), .carryIn(carryIn),
    .halfWr(halfWr), .halfIn(halfIn),
    .ovfWr(ovfWr), .ovfIn(ovfIn),
    .resultVal(result_q), .statusVal(statusVal)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Result, helper, stack
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      result_q <= `MCSFR_RST_ZERO;
      helper_q <= `MCSFR_RST_ZERO;
      stack_q <= `MCSFR_RST_STACK;
    end
    else if (clkEn)
    begin
      result_q <= resultD;
      helper_q <= helperWr ? helperIn : (anyWr && selHelper) ? wrVal : helper_q;
      stack_q <= stackD;
    end
  end

  // Core control and pointer select
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      core_q <= `MCSFR_RST_ZERO;
      psel_q <= 1'b0;
    end
    else if (clkEn)
    begin
      if (anyWr && selCore)
        core_q <= wrVal & `MCSFR_CC_MASK;
      if (anyWr && selPsel)
        psel_q <= wrVal[0];
    end
  end

  // Read data and registered views
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      rdata_q <= `MCSFR_RST_ZERO;
      hit_q <= 1'b0;
      bitOk_q <= 1'b0;
      aptr_q <= 16'h0000;
      bank_q <= 5'h00;
      status_q <= `MCSFR_RST_ZERO;
    end
    else if (clkEn)
    begin
      if (sfrRd)
        rdata_q <= curByte;
      hit_q <= anySel;
      bitOk_q <= bitOk;
      aptr_q <= activePtr;
      bank_q <= {statusVal[`MCSFR_ST_BANK_HI:`MCSFR_ST_BANK_LO], 3'b000};
      status_q <= statusVal;
    end
  end

  // Output assignments from flops
  assign sfrRdata = rdata_q;
  assign sfrHit = hit_q;
  assign bitAddressable = bitOk_q;
  assign resultOut = result_q;
  assign helperOut = helper_q;
  assign statusOut = status_q;
  assign stackTopOut = stack_q;
  assign addressPointer = aptr_q;
  assign bankBase = bank_q;
  assign progWriteMode = core_q[`MCSFR_CC_PMW];
  assign baudDouble = core_q[`MCSFR_CC_BAUD];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence s_push;
    clkEn && stackOp == MCSFR_STK_PUSH;
  endsequence

  a_stack_push: assert property (s_push |=> stack_q == $past(stack_q) + 8'h01)
    else $error("stack not incremented on push");
  a_stack_pop: assert property (clkEn && stackOp == MCSFR_STK_POP
    |=> stack_q == $past(stack_q) - 8'h01)
    else $error("stack not decremented on pop");
  a_parity_track: assert property (clkEn |=> status_q[0] == ^$past(result_q))
    else $error("parity mismatch");
  a_core_low_zero: assert property (core_q[1:0] == 2'b00)
    else $error("core control low bits nonzero");
  a_ptr_select: assert property (clkEn |=> aptr_q == ($past(psel_q) ? $past(ptr1) : $past(ptr0)))
    else $error("wrong active pointer");
  a_bank_base: assert property (clkEn |=> bank_q[2:0] == 3'b000 && bank_q[4:3] == $past(statusVal[4:3]))
    else $error("bank base wrong");
  a_bit_only_col: assert property (clkEn && bitWr && !bitOk && !sfrWr && stackOp == MCSFR_STK_NONE
    |=> stack_q == $past(stack_q))
    else $error("bit write outside bit column");
  a_carry_set: assert property (clkEn && carryWr |=> statusVal[7] == $past(carryIn))
    else $error("carry not updated");
  a_ovf_set: assert property (clkEn && ovfWr |=> statusVal[2] == $past(ovfIn))
    else $error("overflow not updated");
  a_half_set: assert property (clkEn && halfWr |=> statusVal[6] == $past(halfIn))
    else $error("half carry not updated");
  a_pmw_follow: assert property (clkEn && sfrWr && selCore && !bitWr
    |=> progWriteMode == $past(sfrWdata[4]))
    else $error("program write mode not set");
endmodule // mcsfr_core
`default_nettype wire

// *** hdl/mcsfr_params.svh ***
// Constants for the core special function register set
`ifndef MCSFR_PARAMS_SVH
`define MCSFR_PARAMS_SVH

// Register addresses
`define MCSFR_ADDR_STACK 8'h81
`define MCSFR_ADDR_PTRL 8'h82
`define MCSFR_ADDR_PTRH 8'h83
`define MCSFR_ADDR_PTR1L 8'h84
`define MCSFR_ADDR_PTR1H 8'h85
`define MCSFR_ADDR_CORE 8'h87
`define MCSFR_ADDR_PSEL 8'h92
`define MCSFR_ADDR_STATUS 8'hD0
`define MCSFR_ADDR_RESULT 8'hE0
`define MCSFR_ADDR_HELPER 8'hF0

// Reset values
`define MCSFR_RST_ZERO 8'h00
`define MCSFR_RST_STACK 8'h07

// Status word fields
`define MCSFR_ST_CARRY 7
`define MCSFR_ST_HALF 6
`define MCSFR_ST_UF0 5
`define MCSFR_ST_BANK_HI 4
`define MCSFR_ST_BANK_LO 3
`define MCSFR_ST_OVF 2
`define MCSFR_ST_UF1 1
`define MCSFR_ST_PAR 0

// Core control fields
`define MCSFR_CC_BAUD 7
`define MCSFR_CC_PMW 4
`define MCSFR_CC_MASK 8'hFC
`define MCSFR_PSEL_MASK 8'h01

// Bit addressable column
`define MCSFR_BITCOL_MASK 8'h07
`define MCSFR_BITCOL_VAL 8'h00
`define MCSFR_BANK_SHIFT 3

`endif

// *** hdl/mcsfr_pkg.sv ***
// Types for the core special function register set
package mcsfr_pkg;
  // Stack pointer operation
  typedef enum logic [1:0] {
    MCSFR_STK_NONE = 2'b00,
    MCSFR_STK_PUSH = 2'b01,
    MCSFR_STK_POP = 2'b10
  } mcsfr_stk_t;
endpackage

// *** hdl/mcsfr_pointer_pair.sv ***
// One 16-bit data pointer, byte or word writable
`timescale 1ns/1ps
`default_nettype none
`include "mcsfr_params.svh"
module mcsfr_pointer_pair
  import mcsfr_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clkEn,
  // Byte writes
  input wire logic wrLow,
  input wire logic wrHigh,
  input wire logic [7:0] wrByte,
  // Word write
  input wire logic wrWord,
  input wire logic [15:0] wordIn,
  // Stored value
  output logic [15:0] value
);
  logic [7:0] low_q;
  logic [7:0] high_q;
  wire [7:0] lowD;
  wire [7:0] highD;

  // Word write takes priority over byte write
  assign lowD = wrWord ? wordIn[7:0] : wrByte;
  assign highD = wrWord ? wordIn[15:8] : wrByte;
  assign value = {high_q, low_q};

  // Pointer bytes
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      low_q <= `MCSFR_RST_ZERO;
      high_q <= `MCSFR_RST_ZERO;
    end
    else if (clkEn)
    begin
      if (wrWord || wrLow)
        low_q <= lowD;
      if (wrWord || wrHigh)
        high_q <= highD;
    end
  end
endmodule // mcsfr_pointer_pair
`default_nettype wire

// *** hdl/mcsfr_status_word.sv ***
// Program status word with hardware parity
`timescale 1ns/1ps
`default_nettype none
`include "mcsfr_params.svh"
module mcsfr_status_word
  import mcsfr_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clkEn,
  // Software write
  input wire logic swWr,
  input wire logic [7:0] swData,
  // Datapath flag updates
  input wire logic carryWr,
  input wire logic carryIn,
  input wire logic halfWr,
  input wire logic halfIn,
  input wire logic ovfWr,
  input wire logic ovfIn,
  // Result register for parity
  input wire logic [7:0] resultVal,
  // Status out
  output logic [7:0] statusVal
);
  logic [6:0] flags_q;
  wire parity;

  // Odd count of ones in result register
  assign parity = ^resultVal;
  assign statusVal = {flags_q, parity};

  // Flags; datapath updates win over software writes
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      flags_q <= 7'(`MCSFR_RST_ZERO);
    else if (clkEn)
    begin
      if (swWr)
        flags_q <= {swData[7:1]};
      if (carryWr)
        flags_q[`MCSFR_ST_CARRY-1] <= carryIn;
      if (halfWr)
        flags_q[`MCSFR_ST_HALF-1] <= halfIn;
      if (ovfWr)
        flags_q[`MCSFR_ST_OVF-1] <= ovfIn;
    end
  end
endmodule // mcsfr_status_word
`default_nettype wire

// *** dv/mcsfr_dp_model.sv ***
// Behavioural model of the instruction datapath beside the registers
`timescale 1ns/1ps
`default_nettype none
module mcsfr_dp_model
  import mcsfr_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Result, helper and flag updates
  output logic resultWr,
  output logic [7:0] resultIn,
  output logic helperWr,
  output logic [7:0] helperIn,
  output logic carryWr,
  output logic carryIn,
  output logic halfWr,
  output logic halfIn,
  output logic ovfWr,
  output logic ovfIn,
  // Stack and pointer operations
  output mcsfr_stk_t stackOp,
  output logic ptrWordWr,
  output logic [15:0] ptrWordIn
);
  // ----------------------------------------
  // Datapath operations
  // ----------------------------------------
  // Idle at time zero
  initial
  begin
    {ptrWordWr, ovfWr, halfWr, carryWr, helperWr, resultWr} = '0;
    {resultIn, helperIn, carryIn, halfIn, ovfIn, ptrWordIn} = '0;
    stackOp = MCSFR_STK_NONE;
  end

  // One-cycle operation; result, helper and pointer data is inverted on release so it is never held
  task automatic issue(input logic [5:0] strb, input logic [15:0] v, input mcsfr_stk_t op);
    @(negedge sys_clk);
    {ptrWordWr, ovfWr, halfWr, carryWr, helperWr, resultWr} = strb;
    resultIn = v[7:0];
    helperIn = v[7:0];
    {ovfIn, halfIn, carryIn} = v[2:0];
    ptrWordIn = v;
    stackOp = op;
    @(negedge sys_clk);
    {ptrWordWr, ovfWr, halfWr, carryWr, helperWr, resultWr} = '0;
    stackOp = MCSFR_STK_NONE;
    resultIn = ~resultIn;
    helperIn = ~helperIn;
    ptrWordIn = ~ptrWordIn;
  endtask
endmodule // mcsfr_dp_model
`default_nettype wire

// *** dv/mcsfr_core_tb.sv ***
// Self-checking bench for the core special function registers
`timescale 1ns/1ps
`default_nettype none
module mcsfr_core_tb
  import mcsfr_pkg::*;
;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic sys_clk = 1'b0, srst = 1'b1, clkEn = 1'b1;
  logic sfrWr = 1'b0, sfrRd = 1'b0, bitWr = 1'b0, bitVal = 1'b0;
  logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00;
  logic [2:0] bitIdx = 3'h0;
  logic resultWr, helperWr, carryWr, carryIn, halfWr, halfIn, ovfWr, ovfIn, ptrWordWr;
  logic [7:0] resultIn, helperIn, sfrRdata, resultOut, helperOut, statusOut, stackTopOut;
  logic [15:0] ptrWordIn, addressPointer;
  logic [4:0] bankBase;
  logic sfrHit, bitAddressable, progWriteMode, baudDouble;
  mcsfr_stk_t stackOp;
  int mismatches = 0, n_tests = 0, cycles = 0;
  logic [7:0] regAddr [10] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h87, 8'h92, 8'hD0,
    8'hE0, 8'hF0};

  mcsfr_core i_mcsfr_core (.sys_clk, .srst, .clkEn, .sfrAddr, .sfrWr, .sfrRd, .sfrWdata,
    .bitWr, .bitIdx, .bitVal, .resultWr, .resultIn, .helperWr, .helperIn, .carryWr,
    .carryIn, .halfWr, .halfIn, .ovfWr, .ovfIn, .stackOp, .ptrWordWr, .ptrWordIn,
    .sfrRdata, .sfrHit, .bitAddressable, .resultOut, .helperOut, .statusOut,
    .stackTopOut, .addressPointer, .bankBase, .progWriteMode, .baudDouble);

  mcsfr_dp_model i_mcsfr_dp_model (.sys_clk, .resultWr, .resultIn, .helperWr, .helperIn,
    .carryWr, .carryIn, .halfWr, .halfIn, .ovfWr, .ovfIn, .stackOp, .ptrWordWr,
    .ptrWordIn);

  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;

  // Hang guard
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    sfrAddr = a;
    sfrWdata = d;
    sfrWr = 1'b1;
    @(negedge sys_clk);
    sfrWr = 1'b0;
  endtask

  task automatic bw(input logic [7:0] a, input logic [2:0] i, input logic v);
    @(negedge sys_clk);
    sfrAddr = a;
    bitIdx = i;
    bitVal = v;
    bitWr = 1'b1;
    @(negedge sys_clk);
    bitWr = 1'b0;
  endtask

  // Read data is captured at the edge and shown one cycle later
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    sfrAddr = a;
    sfrRd = 1'b1;
    @(negedge sys_clk);
    sfrRd = 1'b0;
    chk("sfrRdata", 16'(exp), 16'(sfrRdata));
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    repeat (4) @(negedge sys_clk);
    srst = 1'b0;
    foreach (regAddr[k]) rd(regAddr[k], (k == 0) ? 8'h07 : 8'h00);
    chk("sfrHit", 16'h0001, 16'(sfrHit));
    chk("bitAddressable", 16'h0001, 16'(bitAddressable));
    @(negedge sys_clk);
    sfrAddr = 8'h86;
    @(negedge sys_clk);
    chk("sfrHit", 16'h0000, 16'(sfrHit));
    $display("reset values done");
    wr(8'hE0, 8'h5A);
    wr(8'hF0, 8'hA5);
    rd(8'hE0, 8'h5A);
    rd(8'hF0, 8'hA5);
    chk("resultOut", 16'h005A, 16'(resultOut));
    i_mcsfr_dp_model.issue(6'h02, 16'h003C, MCSFR_STK_NONE);
    @(negedge sys_clk);
    clkEn = 1'b0;
    wr(8'hF0, 8'h11);
    clkEn = 1'b1;
    rd(8'hF0, 8'h3C);
    chk("helperOut", 16'h003C, 16'(helperOut));
    $display("result and helper done");
    wr(8'hE0, 8'h07);
    wr(8'hD0, 8'h00);
    rd(8'hD0, 8'h01);
    i_mcsfr_dp_model.issue(6'h01, 16'h0003, MCSFR_STK_NONE);
    rd(8'hD0, 8'h00);
    chk("statusOut", 16'h0000, 16'(statusOut));
    $display("parity done");
    for (int c = 0; c < 4; c++)
    begin
      wr(8'hD0, 8'h22 | 8'(c << 3));
      rd(8'hD0, 8'h22 | 8'(c << 3));
      chk("bankBase", 16'(c * 8), 16'(bankBase));
    end
    i_mcsfr_dp_model.issue(6'h1C, 16'h0007, MCSFR_STK_NONE);
    rd(8'hD0, 8'hFE);
    bw(8'hD0, 3'h7, 1'b0);
    rd(8'hD0, 8'h7E);
    bw(8'h81, 3'h0, 1'b1);
    rd(8'h81, 8'h07);
    chk("bitAddressable", 16'h0000, 16'(bitAddressable));
    $display("status flags done");
    i_mcsfr_dp_model.issue(6'h00, 16'h0000, MCSFR_STK_PUSH);
    i_mcsfr_dp_model.issue(6'h00, 16'h0000, MCSFR_STK_PUSH);
    rd(8'h81, 8'h09);
    i_mcsfr_dp_model.issue(6'h00, 16'h0000, MCSFR_STK_POP);
    chk("stackTopOut", 16'h0008, 16'(stackTopOut));
    $display("stack done");
    foreach (regAddr[k]) if (k >= 1 && k <= 4) wr(regAddr[k], 8'h12 + 8'(k * 8'h22));
    @(negedge sys_clk);
    chk("addressPointer", 16'h5634, addressPointer);
    wr(8'h92, 8'hFF);
    rd(8'h92, 8'h01);
    chk("addressPointer", 16'h9A78, addressPointer);
    i_mcsfr_dp_model.issue(6'h20, 16'hABCD, MCSFR_STK_NONE);
    rd(8'h84, 8'hCD);
    rd(8'h85, 8'hAB);
    rd(8'h82, 8'h34);
    wr(8'h92, 8'h00);
    i_mcsfr_dp_model.issue(6'h20, 16'h1357, MCSFR_STK_NONE);
    rd(8'h83, 8'h13);
    chk("addressPointer", 16'h1357, addressPointer);
    $display("pointers done");
    wr(8'h87, 8'hFC);
    rd(8'h87, 8'hFC);
    chk("progWriteMode", 16'h0001, 16'(progWriteMode));
    chk("baudDouble", 16'h0001, 16'(baudDouble));
    wr(8'h87, 8'h6C);
    rd(8'h87, 8'h6C);
    chk("progWriteMode", 16'h0000, 16'(progWriteMode));
    chk("baudDouble", 16'h0000, 16'(baudDouble));
    $display("core control done");
    tally_and_finish();
  end
endmodule // mcsfr_core_tb
`default_nettype wire
